/* File: serial_flash_read_engine.sv */
`timescale 1ns/1ps
// Functional notes
// RULE1: basic read captures address on rising clock, drives data on falling clock.
// RULE2: start anywhere, address increments after each byte, wraps to zero at top.
// RULE3: host drops select, sends opcode, 3-byte address, reads; may end anytime.
// RULE4: fast read inserts one dummy byte after address before data.
// RULE5: during write cycle refuse fast, double-rate and multi-line reads, cycle untouched.
// RULE6: single double-rate read: opcode one bit per clock, then two bits per clock.
// RULE7: single double-rate read waits six dummy clocks before data.
// RULE8: dual read: address on two lines, four dummy clocks, data on two lines.
// RULE9: dual double-rate read: opcode serial, then two bits per edge.
// RULE10: dual double-rate read waits six dummy clocks before data.
// RULE11: host sets quad enable before quad read.
// RULE12: quad read: address on four lines, six dummy cycles, data until select rises.
// RULE13: quad enhance: mode byte, four dummy, next frame skips opcode.
// RULE14: enhance kept when mode nibbles complement, else cleared for next frame.
// RULE15: quad double-rate read: opcode serial, then four bits per edge.
// RULE16: quad double-rate read: eight dummy clocks between address and data.
// RULE17: quad double-rate enhance: mode byte, seven dummy clocks, next frame skips opcode.
// RULE18: host sets quad enable before quad double-rate read.
// RULE19: line two is write protect unless quad enable is set.
// RULE20: write-in-progress holds one through the write cycle, then clears.
// RULE21: data lines released whenever select high or not in data phase.
// RULE22: select rising discards partial frame; decoding restarts on next select fall.
module serial_flash_read_engine
  import flash_read_pkg::*;
#(
  parameter logic [ADDR_W-1:0] LAST_ADDR = 24'hffffff
) (
  // clock and reset
  input  wire logic              CLK_IN,
  input  wire logic              RST_IN,
  // serial link pins
  input  wire logic              CS_N_IN,
  input  wire logic              SCLK_IN,
  input  wire logic [3:0]        IO_IN,
  output logic      [3:0]        IO_OUT,
  output logic      [3:0]        IO_OE_N_OUT,
  // array read port
  output logic      [ADDR_W-1:0] MEM_ADDR_OUT,
  input  wire logic [7:0]        MEM_DATA_IN,
  // status
  input  wire logic              QUAD_ENABLE_IN,
  input  wire logic              WRITE_CYCLE_START_IN,
  input  wire logic              WRITE_CYCLE_DONE_IN,
  output logic                   WRITE_IN_PROGRESS_OUT,
  output logic                   WRITE_PROTECT_ACTIVE_OUT
);

  typedef struct packed {
    state_t              st;
    cfg_t                cfg;
    logic [4:0]          cnt;
    logic                started;
    logic                sclk_q;
    logic [7:0]          sh;
    logic [ADDR_W-1:0]   addr;
    logic                enh;
    logic                write_in_progress_bit;
    logic [3:0]          io;
    logic [3:0]          oe_n;
    logic                wp_act;
  } regs_t;

  regs_t r;
  regs_t n;

  logic       cs_n_s;
  logic       sclk_s;
  logic [3:0] io_s;

  // all host pins cross through the same two-stage synchroniser
  pin_sync #(
    .W(6)
  ) u_sync (
    .clk_in    (CLK_IN),
    .rst_in    (RST_IN),
    .d_in      ({CS_N_IN, SCLK_IN, IO_IN}),
    .rst_val_in(6'h24), // select high, clock low, protect line at its pull-up level
    .q_out     ({cs_n_s, sclk_s, io_s})
  );

  // capture beats needed for a field, from its bit count and width code
  function automatic logic [4:0] beats(input logic [4:0] bits, input logic [1:0] lg);
    return 5'(bits >> lg);
  endfunction

  // shift captured lanes into a word, line zero is least significant
  function automatic logic [ADDR_W-1:0] shift_addr(input logic [ADDR_W-1:0] a,
                                                   input logic [3:0] d,
                                                   input logic [1:0] lg);
    logic [ADDR_W-1:0] v;
    v = a;
    unique case (lg)
      2'd0:    v = {a[ADDR_W-2:0], d[0]};
      2'd1:    v = {a[ADDR_W-3:0], d[1:0]};
      default: v = {a[ADDR_W-5:0], d[3:0]};
    endcase
    return v;
  endfunction

  logic rise;
  logic fall;
  logic cap;
  logic launch;
  logic [7:0]  obyte;
  logic [7:0]  op_next;
  logic [7:0]  mode_next;
  cfg_t        dec;

  always_comb begin
    n         = r;
    rise      = sclk_s & ~r.sclk_q;
    fall      = ~sclk_s & r.sclk_q;
    // double rate waits for a rising edge so fields align on whole clocks
    cap       = r.cfg.ddr ? (rise | (fall & r.started)) : rise; // RULE1 RULE6 RULE9 RULE15
    launch    = r.cfg.ddr ? (rise | fall) : fall; // RULE1 RULE8
    obyte     = (r.cnt == 5'd0) ? MEM_DATA_IN : r.sh;
    op_next   = {r.sh[6:0], io_s[0]};
    mode_next = 8'(shift_addr({16'h0000, r.sh}, io_s, r.cfg.lg));
    dec       = decode_cmd(op_next);
    n.sclk_q  = sclk_s;

    // write cycle flag, start wins over done
    if (WRITE_CYCLE_DONE_IN) begin
      n.write_in_progress_bit = 1'b0; // RULE20
    end
    if (WRITE_CYCLE_START_IN) begin
      n.write_in_progress_bit = 1'b1; // RULE20
    end
    // line two only acts as protect input outside quad use
    n.wp_act = ~QUAD_ENABLE_IN & ~io_s[2]; // RULE19

    unique case (r.st)
      ST_IDLE: begin
        n.oe_n    = 4'hf;
        n.cnt     = 5'd0;
        n.started = 1'b0;
        if (!cs_n_s) begin
          // address shifts in from zero, so partial values never pass the top
          n.addr = '0; // RULE2
          if (r.enh) begin
            // continuation frame starts straight at the address
            n.st = r.write_in_progress_bit ? ST_REJECT : ST_ADDR; // RULE13 RULE17 RULE5
          end else begin
            n.st = ST_OPCODE; // RULE22
          end
        end
      end
      ST_OPCODE: begin
        if (rise) begin
          n.sh  = op_next;
          n.cnt = r.cnt + 5'd1;
          if (r.cnt == OPCODE_BITS - 5'd1) begin
            n.cnt = 5'd0;
            n.cfg = dec;
            if (!dec.valid || (dec.guarded && r.write_in_progress_bit)) begin
              n.st = ST_REJECT; // RULE5
            end else if (dec.quad && !QUAD_ENABLE_IN) begin
              n.st = ST_REJECT; // RULE11 RULE18
            end else begin
              n.st = ST_ADDR; // RULE3
            end
          end
        end
      end
      ST_ADDR: begin
        if (rise) begin
          n.started = 1'b1;
        end
        if (cap || (rise && r.cfg.ddr)) begin
          n.addr = shift_addr(r.addr, io_s, r.cfg.lg); // RULE8 RULE12
          n.cnt  = r.cnt + 5'd1;
          if (r.cnt == beats(ADDR_BITS, r.cfg.lg) - 5'd1) begin
            n.cnt = 5'd0;
            if (r.cfg.has_mode) begin
              n.st = ST_MODE; // RULE13 RULE17
            end else if (r.cfg.dummy != 5'd0) begin
              n.st = ST_DUMMY; // RULE4
            end else begin
              n.st = ST_DATA; // RULE1
            end
          end
        end
      end
      ST_MODE: begin
        if (cap) begin
          n.sh  = mode_next;
          n.cnt = r.cnt + 5'd1;
          if (r.cnt == beats(MODE_BITS, r.cfg.lg) - 5'd1) begin
            n.cnt = 5'd0;
            // complementary nibbles keep the opcode-less mode alive
            n.enh = (mode_next[7:4] == ~mode_next[3:0]); // RULE14
            n.st  = ST_DUMMY; // RULE12 RULE16
          end
        end
      end
      ST_DUMMY: begin
        if (cap) begin
          n.cnt = r.cnt + 5'd1;
          if (r.cnt == r.cfg.dummy - 5'd1) begin
            n.cnt = 5'd0;
            n.st  = ST_DATA; // RULE4 RULE7 RULE8 RULE10 RULE13 RULE17
          end
        end
      end
      ST_DATA: begin
        if (launch) begin
          // first beat of a byte loads the array word for the current address
          unique case (r.cfg.lg)
            2'd0: begin
              n.io   = {2'b00, obyte[7], 1'b0};
              n.oe_n = 4'b1101; // RULE1
              n.sh   = {obyte[6:0], 1'b0};
            end
            2'd1: begin
              n.io   = {2'b00, obyte[7:6]};
              n.oe_n = 4'b1100; // RULE8 RULE9
              n.sh   = {obyte[5:0], 2'b00};
            end
            default: begin
              n.io   = obyte[7:4];
              n.oe_n = 4'b0000; // RULE12 RULE15
              n.sh   = {obyte[3:0], 4'h0};
            end
          endcase
          n.cnt = r.cnt + 5'd1;
          if (r.cnt == beats(5'd8, r.cfg.lg) - 5'd1) begin
            n.cnt = 5'd0;
            // next address settles long before the next launch edge
            n.addr = (r.addr == LAST_ADDR) ? '0 : r.addr + 1'b1; // RULE2
          end
        end
      end
      ST_REJECT: begin
        // refused frame: lines stay released until select rises
        n.oe_n = 4'hf; // RULE5
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // select high ends any frame and releases the lines
    if (cs_n_s) begin
      n.st   = ST_IDLE; // RULE22 RULE3
      n.oe_n = 4'hf; // RULE21
    end
  end

  // single register stage for all state
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      r        <= '0;
      r.st     <= ST_IDLE;
      r.oe_n   <= 4'hf;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign IO_OUT                   = r.io;
  assign IO_OE_N_OUT              = r.oe_n;
  assign MEM_ADDR_OUT             = r.addr;
  assign WRITE_IN_PROGRESS_OUT    = r.write_in_progress_bit;
  assign WRITE_PROTECT_ACTIVE_OUT = r.wp_act;

endmodule // serial_flash_read_engine

/* File: flash_read_pkg.sv */
package flash_read_pkg;

  // frame states, gray coded along idle-opcode-addr-mode-dummy-data
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR   = 3'b011,
    ST_MODE   = 3'b010,
    ST_DUMMY  = 3'b110,
    ST_DATA   = 3'b111,
    ST_REJECT = 3'b101
  } state_t;

  // read command codes
  localparam logic [7:0] NORMAL_READ_CMD              = 8'h03;
  localparam logic [7:0] FAST_READ_CMD                = 8'h0b;
  localparam logic [7:0] SINGLE_DOUBLE_RATE_READ_CMD  = 8'h0d;
  localparam logic [7:0] DUAL_IO_READ_CMD             = 8'hbb;
  localparam logic [7:0] DUAL_IO_DOUBLE_RATE_READ_CMD = 8'hbd;
  localparam logic [7:0] QUAD_IO_READ_CMD             = 8'heb;
  localparam logic [7:0] QUAD_IO_DOUBLE_RATE_READ_CMD = 8'hed;

  // frame field sizes
  localparam logic [4:0] OPCODE_BITS = 5'd8;
  localparam logic [4:0] ADDR_BITS   = 5'd24;
  localparam logic [4:0] MODE_BITS   = 5'd8;
  localparam int         ADDR_W      = 24;

  // dummy clocks per command (quad ones follow the mode byte)
  localparam logic [4:0] FAST_DUMMY_CLOCKS        = 5'd8;
  localparam logic [4:0] SINGLE_DDR_DUMMY_CLOCKS  = 5'd6;
  localparam logic [4:0] DUAL_DUMMY_CLOCKS        = 5'd4;
  localparam logic [4:0] DUAL_DDR_DUMMY_CLOCKS    = 5'd6;
  localparam logic [4:0] QUAD_ENH_DUMMY_CLOCKS    = 5'd4;
  localparam logic [4:0] QUAD_DDR_ENH_DUMMY_CLOCKS = 5'd7;

  // lane width code: 0 one line, 1 two lines, 2 four lines
  typedef struct packed {
    logic       valid;
    logic [1:0] lg;
    logic       ddr;
    logic       has_mode;
    logic [4:0] dummy;    // in capture events
    logic       guarded;  // refused while a write cycle runs
    logic       quad;
  } cfg_t;

  function automatic cfg_t make_cfg(input logic [1:0] lg, input logic ddr,
                                    input logic [4:0] clocks, input logic guarded);
    cfg_t c;
    c.valid    = 1'b1;
    c.lg       = lg;
    c.ddr      = ddr;
    c.has_mode = (lg == 2'd2);
    c.dummy    = ddr ? 5'(clocks << 1) : clocks;
    c.guarded  = guarded;
    c.quad     = (lg == 2'd2);
    return c;
  endfunction

  function automatic cfg_t decode_cmd(input logic [7:0] op);
    cfg_t c;
    c = '0;
    unique case (op)
      NORMAL_READ_CMD:              c = make_cfg(2'd0, 1'b0, 5'd0, 1'b0);
      FAST_READ_CMD:                c = make_cfg(2'd0, 1'b0, FAST_DUMMY_CLOCKS, 1'b1);
      SINGLE_DOUBLE_RATE_READ_CMD:  c = make_cfg(2'd0, 1'b1, SINGLE_DDR_DUMMY_CLOCKS, 1'b1);
      DUAL_IO_READ_CMD:             c = make_cfg(2'd1, 1'b0, DUAL_DUMMY_CLOCKS, 1'b1);
      DUAL_IO_DOUBLE_RATE_READ_CMD: c = make_cfg(2'd1, 1'b1, DUAL_DDR_DUMMY_CLOCKS, 1'b1);
      QUAD_IO_READ_CMD:             c = make_cfg(2'd2, 1'b0, QUAD_ENH_DUMMY_CLOCKS, 1'b1);
      QUAD_IO_DOUBLE_RATE_READ_CMD: c = make_cfg(2'd2, 1'b1, QUAD_DDR_ENH_DUMMY_CLOCKS, 1'b1);
      default:                      c = '0;
    endcase
    return c;
  endfunction

endpackage

/* File: pin_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser for pins arriving from the host's domain
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  input  wire logic [W-1:0] rst_val_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // first stage feeds only the second stage; reset loads the idle pin levels
  // so no false select or clock edge shows up right after release
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_r <= rst_val_in;
      q_r    <= rst_val_in;
    end else begin
      meta_r <= d_in;
      q_r    <= meta_r;
    end
  end

  // rst_val_in is a constant tie-off, output comes straight from the second stage
  assign q_out = q_r;

endmodule // pin_sync

/* File: flash_read_chk.sv */
`timescale 1ns/1ps
// watches the engine's pins for status and lane faults
module flash_read_chk
  import flash_read_pkg::*;
#(
  parameter logic [ADDR_W-1:0] LAST_ADDR = 24'hffffff
) (
  // clock and reset
  input wire logic              CLK_IN,
  input wire logic              RST_IN,
  // link and array
  input wire logic              CS_N_IN,
  input wire logic [3:0]        IO_IN,
  input wire logic [3:0]        IO_OE_N_OUT,
  input wire logic [ADDR_W-1:0] MEM_ADDR_OUT,
  // status
  input wire logic              QUAD_ENABLE_IN,
  input wire logic              WRITE_CYCLE_START_IN,
  input wire logic              WRITE_CYCLE_DONE_IN,
  input wire logic              WRITE_IN_PROGRESS_OUT,
  input wire logic              WRITE_PROTECT_ACTIVE_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  // 8 cycles covers the select sync plus the release delay
  a_cs_high_release: assert property (CS_N_IN [*8] |-> IO_OE_N_OUT == 4'hf)
    else $error("lines driven while select high");
  a_lane_pattern: assert property (IO_OE_N_OUT inside {4'hf, 4'hd, 4'hc, 4'h0})
    else $error("illegal lane enable pattern");
  a_wip_set: assert property (WRITE_CYCLE_START_IN |=> WRITE_IN_PROGRESS_OUT)
    else $error("write flag not set by start");
  a_wip_clear: assert property (WRITE_CYCLE_DONE_IN && !WRITE_CYCLE_START_IN |=>
    !WRITE_IN_PROGRESS_OUT) else $error("write flag not cleared by done");
  a_wip_hold: assert property (WRITE_IN_PROGRESS_OUT && !WRITE_CYCLE_DONE_IN |=>
    WRITE_IN_PROGRESS_OUT) else $error("write flag dropped early");
  a_wip_rise_cause: assert property ($rose(WRITE_IN_PROGRESS_OUT) |->
    $past(WRITE_CYCLE_START_IN)) else $error("write flag rose without start");
  a_wp_off_quad: assert property (QUAD_ENABLE_IN [*2] |-> !WRITE_PROTECT_ACTIVE_OUT)
    else $error("protect active with quad enable");
  a_wp_on_low: assert property ((!QUAD_ENABLE_IN && !IO_IN[2]) [*6] |->
    WRITE_PROTECT_ACTIVE_OUT) else $error("protect missing with line two low");
  a_wp_off_high: assert property ((!QUAD_ENABLE_IN && IO_IN[2]) [*6] |->
    !WRITE_PROTECT_ACTIVE_OUT) else $error("protect with line two high");
  a_addr_range: assert property (MEM_ADDR_OUT <= LAST_ADDR)
    else $error("array address past top");
  a_upper_lanes_qe: assert property ((!QUAD_ENABLE_IN) [*8] |-> IO_OE_N_OUT[3:2] == 2'b11)
    else $error("upper lanes driven without quad enable");

  // main scenarios reached
  c_quad_data: cover property (IO_OE_N_OUT == 4'h0);
  c_read_busy: cover property (WRITE_IN_PROGRESS_OUT && !IO_OE_N_OUT[1]);
  c_write_done: cover property ($fell(WRITE_IN_PROGRESS_OUT));
endmodule // flash_read_chk

bind serial_flash_read_engine flash_read_chk #(.LAST_ADDR(LAST_ADDR)) i_chk (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .CS_N_IN(CS_N_IN), .IO_IN(IO_IN),
  .IO_OE_N_OUT(IO_OE_N_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT), .QUAD_ENABLE_IN(QUAD_ENABLE_IN),
  .WRITE_CYCLE_START_IN(WRITE_CYCLE_START_IN), .WRITE_CYCLE_DONE_IN(WRITE_CYCLE_DONE_IN),
  .WRITE_IN_PROGRESS_OUT(WRITE_IN_PROGRESS_OUT),
  .WRITE_PROTECT_ACTIVE_OUT(WRITE_PROTECT_ACTIVE_OUT));

/* File: flash_host.sv */
`timescale 1ns/1ps
// host controller model: owns select, link clock and lines outside data
module flash_host (
  input  wire logic       clk_in,
  input  wire logic [3:0] io_in,
  input  wire logic [3:0] oe_n_in,
  output logic            cs_n_out,
  output logic            sclk_out,
  output logic [3:0]      io_out,
  output logic [3:0]      drv_out
);
  logic [7:0] sh_r;
  logic [7:0] rx_q[$];
  logic [3:0] oe_acc_r;
  int         lanes;
  // link clock stands low between frames
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    io_out = 4'h0;
    drv_out = 4'h0;
  end
  // one link edge; lines move mid half period, clear of both edges
  task automatic half(input bit smp);
    repeat (2) @(negedge clk_in);
    if (smp) begin
      sh_r = 8'((sh_r << lanes) | (lanes == 1 ? {3'h0, io_in[1]} :
                                   lanes == 2 ? {2'h0, io_in[1:0]} : io_in));
      oe_acc_r &= oe_n_in;
    end
    sclk_out = ~sclk_out;
    repeat (2) @(negedge clk_in);
  endtask
  // select alone, for frames that the bench cuts short
  task automatic sel(input bit v);
    cs_n_out = v;
  endtask
  // msb first, highest lane carries the higher bit
  task automatic send(input logic [23:0] v, input int n, input int w, input bit ddr);
    drv_out = 4'((1 << w) - 1);
    for (int i = n - w; i >= 0; i -= w) begin
      io_out = 4'(v >> i);
      half(1'b0);
      if (!ddr) half(1'b0);
    end
    drv_out = 4'h0;
  endtask
  // sample just before the edge after each launch
  task automatic recv(input int nb, input int w, input bit ddr);
    lanes = w;
    if (ddr) half(1'b0);
    repeat (nb) begin
      repeat (8 / w) begin
        half(1'b1);
        if (!ddr) half(1'b0);
      end
      rx_q.push_back(sh_r);
    end
  endtask
  // dummy clocks run with all lines released
  task automatic frame(input logic [7:0] op, input bit skip, input logic [23:0] a, input int w,
                       input bit ddr, input int dck, input logic [7:0] md, input int nb);
    rx_q = {};
    oe_acc_r = 4'hf;
    cs_n_out = 1'b0;
    repeat (2) @(negedge clk_in);
    if (!skip) send(24'(op), 8, 1, 1'b0);
    send(a, 24, w, ddr);
    if (w == 4) send(24'(md), 8, 4, ddr);
    repeat (2 * dck) half(1'b0);
    recv(nb, w, ddr);
    // double rate ends on an odd edge count; bring the clock back to rest low
    if (sclk_out) half(1'b0);
    cs_n_out = 1'b1;
    repeat (6) @(negedge clk_in);
  endtask
endmodule // flash_host

/* File: serial_flash_read_engine_tb_top.sv */
`timescale 1ns/1ps
// bench: host model on the link, flat memory on the array port
module serial_flash_read_engine_tb_top import flash_read_pkg::*;;
  localparam logic [ADDR_W-1:0] TOP_ADDR = 24'h00000f;
  logic              clk;
  logic              rst;
  logic              qe;
  logic              wr_start;
  logic              wr_done;
  logic              wp_lvl;
  logic              cs_n;
  logic              sclk;
  logic [3:0]        host_io;
  logic [3:0]        host_drv;
  logic [3:0]        dev_io;
  logic [3:0]        dev_oe_n;
  logic [3:0]        line;
  logic [ADDR_W-1:0] mem_addr;
  logic              write_in_progress_bit;
  logic              wp_act;
  int                err_total;
  int                check_count;

  always #25 clk = ~clk;
  // undriven line two rests at the protect level, others invert last value
  always_comb begin
    for (int i = 0; i < 4; i++)
      line[i] = !dev_oe_n[i] ? dev_io[i] : host_drv[i] ? host_io[i] : i == 2 ? wp_lvl : ~dev_io[i];
  end

  serial_flash_read_engine #(.LAST_ADDR(TOP_ADDR)) i_dut (
    .CLK_IN(clk), .RST_IN(rst), .CS_N_IN(cs_n), .SCLK_IN(sclk), .IO_IN(line),
    .IO_OUT(dev_io), .IO_OE_N_OUT(dev_oe_n), .MEM_ADDR_OUT(mem_addr),
    .MEM_DATA_IN(mem_addr[7:0] ^ 8'h5a), .QUAD_ENABLE_IN(qe), .WRITE_CYCLE_START_IN(wr_start),
    .WRITE_CYCLE_DONE_IN(wr_done), .WRITE_IN_PROGRESS_OUT(write_in_progress_bit), .WRITE_PROTECT_ACTIVE_OUT(wp_act));
  flash_host i_host (.clk_in(clk), .io_in(line), .oe_n_in(dev_oe_n), .cs_n_out(cs_n),
    .sclk_out(sclk), .io_out(host_io), .drv_out(host_drv));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one frame, then lane use and bytes against the wrapped array image
  task automatic rd(input logic [7:0] op, input bit skip, input logic [23:0] a, input int w,
                    input bit ddr, input int dck, input logic [7:0] md, input int nb,
                    input logic [3:0] oe);
    i_host.frame(op, skip, a, w, ddr, dck, md, nb);
    check("lanes", {4'h0, i_host.oe_acc_r}, {4'h0, oe});
    for (int i = 0; i < nb && oe != 4'hf; i++)
      check("byte", i_host.rx_q[i], 8'((a + i) % (TOP_ADDR + 1)) ^ 8'h5a);
  endtask
  task automatic t_cmds();
    logic [7:0] ops[7];
    int         ws[7];
    int         dk[7];
    logic [3:0] oes[7];
    ops = '{8'h03, 8'h0b, 8'h0d, 8'hbb, 8'hbd, 8'heb, 8'hed};
    ws = '{1, 1, 1, 2, 2, 4, 4};
    dk = '{0, 8, 6, 4, 6, 4, 7};
    oes = '{4'hd, 4'hd, 4'hd, 4'hc, 4'hc, 4'h0, 4'h0};
    qe = 1'b1;
    for (int k = 0; k < 7; k++)
      rd(ops[k], 1'b0, 24'(k + 3), ws[k], k inside {2, 4, 6}, dk[k], 8'hff, 2, oes[k]);
  endtask
  task automatic t_wrap();
    rd(8'h03, 1'b0, 24'h00000e, 1, 1'b0, 0, 8'h00, 3, 4'hd);
  endtask
  // select rises mid address; the partial frame must leave no trace
  task automatic t_abort();
    i_host.sel(1'b0);
    repeat (2) @(negedge clk);
    i_host.send(24'h03, 8, 1, 1'b0);
    i_host.send(24'h005, 12, 1, 1'b0);
    i_host.sel(1'b1);
    repeat (6) @(negedge clk);
    rd(8'h03, 1'b0, 24'h7, 1, 1'b0, 0, 8'h00, 1, 4'hd);
    rd(8'h55, 1'b0, 24'h7, 1, 1'b0, 0, 8'h00, 1, 4'hf);
  endtask
  task automatic t_enh();
    for (int d = 0; d < 2; d++) begin
      rd(d ? 8'hed : 8'heb, 1'b0, 24'h5, 4, d[0], d ? 7 : 4, 8'ha5, 1, 4'h0);
      rd(8'h00, 1'b1, 24'h9, 4, d[0], d ? 7 : 4, 8'hff, 1, 4'h0);
      rd(8'h03, 1'b0, 24'h2, 1, 1'b0, 0, 8'h00, 1, 4'hd);
    end
  endtask
  // guarded reads refused while a write cycle runs, plain read still served
  task automatic t_busy();
    wr_start = 1'b1;
    @(negedge clk);
    wr_start = 1'b0;
    @(negedge clk);
    check("busy", {7'h0, write_in_progress_bit}, 8'h01);
    rd(8'h0b, 1'b0, 24'h4, 1, 1'b0, 8, 8'h00, 1, 4'hf);
    rd(8'hbd, 1'b0, 24'h4, 2, 1'b1, 6, 8'h00, 1, 4'hf);
    rd(8'heb, 1'b0, 24'h4, 4, 1'b0, 4, 8'hff, 1, 4'hf);
    rd(8'h03, 1'b0, 24'h8, 1, 1'b0, 0, 8'h00, 2, 4'hd);
    check("busy", {7'h0, write_in_progress_bit}, 8'h01);
    wr_done = 1'b1;
    @(negedge clk);
    wr_done = 1'b0;
    @(negedge clk);
    check("idle", {7'h0, write_in_progress_bit}, 8'h00);
  endtask
  task automatic t_qe();
    qe = 1'b0;
    rd(8'hed, 1'b0, 24'h6, 4, 1'b1, 7, 8'hff, 1, 4'hf);
    rd(8'heb, 1'b0, 24'h6, 4, 1'b0, 4, 8'hff, 1, 4'hf);
    wp_lvl = 1'b0;
    repeat (6) @(negedge clk);
    check("protect", {7'h0, wp_act}, 8'h01);
    qe = 1'b1;
    repeat (6) @(negedge clk);
    check("protect", {7'h0, wp_act}, 8'h00);
    wp_lvl = 1'b1;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // about 24 frames of some 13 us each; five times that is a hang
  initial begin
    #1_500_000;
    err_total++;
    finish_test();
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    qe = 1'b0;
    wr_start = 1'b0;
    wr_done = 1'b0;
    wp_lvl = 1'b1;
    err_total = 0;
    check_count = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_cmds();
    t_wrap();
    t_abort();
    t_enh();
    t_busy();
    t_qe();
    finish_test();
  end
endmodule // serial_flash_read_engine_tb_top
